/* File: rtl/gcs_pkg.sv */
package gcs_pkg;

   // ************************************************************
   // Control command location and widths
   // ************************************************************
   localparam logic [7:0]  CTRL_OFS_LO  = 8'h00;  // Low byte of word
   localparam logic [7:0]  CTRL_OFS_HI  = 8'h01;  // High byte of word
   localparam int          WORD_W       = 16;

   // ************************************************************
   // Subcommand codes
   // ************************************************************
   localparam logic [15:0] SC_STATUS    = 16'h0000;
   localparam logic [15:0] SC_DEV_TYPE  = 16'h0001;
   localparam logic [15:0] SC_FW_REV    = 16'h0002;
   localparam logic [15:0] SC_HW_REV    = 16'h0003;
   localparam logic [15:0] SC_FL_SUM    = 16'h0004;
   localparam logic [15:0] SC_RST_DATA  = 16'h0005;
   localparam logic [15:0] SC_PREV      = 16'h0007;
   localparam logic [15:0] SC_CHEM      = 16'h0008;
   localparam logic [15:0] SC_FL_REV    = 16'h000c;
   localparam logic [15:0] SC_OSC_IDLE  = 16'h0010;
   localparam logic [15:0] SC_DEEP_SET  = 16'h0011;
   localparam logic [15:0] SC_DEEP_CLR  = 16'h0012;
   localparam logic [15:0] SC_PWROFF_ON = 16'h0013;
   localparam logic [15:0] SC_PWROFF_NO = 16'h0014;
   localparam logic [15:0] SC_IRQ_ON    = 16'h0015;
   localparam logic [15:0] SC_IRQ_OFF   = 16'h0016;
   localparam logic [15:0] SC_LOCK      = 16'h0020;
   localparam logic [15:0] SC_ALGO      = 16'h0021;
   localparam logic [15:0] SC_CAL       = 16'h0040;
   localparam logic [15:0] SC_RESET     = 16'h0041;
   localparam logic [15:0] PREV_LIMIT   = 16'h0020;  // Recall holds codes below

   // ************************************************************
   // Control-status word bit positions
   // ************************************************************
   localparam int B_PIN_ACT  = 15;  // Shutdown pin active
   localparam int B_FA_LOCK  = 14;  // Full-access locked
   localparam int B_LOCKED   = 13;  // Locked
   localparam int B_SUM_OK   = 12;  // Checksum valid
   localparam int B_CC_CAL   = 11;  // Coulomb calibration running
   localparam int B_BRD_CAL  = 10;  // Board calibration running
   localparam int B_IRQ_EN   = 8;   // Host interrupt enable
   localparam int B_PWROFF   = 7;   // Power-off permit
   localparam int B_DEEP_REQ = 6;   // Deep-idle request
   localparam int B_OSC_IDLE = 5;   // Oscillator-off idle
   localparam int B_SLEEP    = 4;   // Sleep
   localparam int B_CPWR     = 3;   // Constant-power gauging
   localparam int B_RUP_OFF  = 2;   // Resistance updates off
   localparam int B_VFIT     = 1;   // Voltage fit
   localparam int B_QEN      = 0;   // Max-capacity updates on

   // ************************************************************
   // Reset values and timing
   // ************************************************************
   localparam logic [15:0] RESP_RST     = 16'h0000;
   localparam logic [15:0] PREV_RST     = 16'h0000;
   localparam logic [15:0] SUM_RST      = 16'h0000;
   localparam int          CLK_HZ       = 25000000;
   localparam int          OSC_START_MS = 6;   // Least wake stretch, ms
   localparam int          OSC_START_CYC = (OSC_START_MS * (CLK_HZ / 1000));

   // Response source of the control command location
   typedef enum logic [3:0] {
      RS_STATUS, RS_DEV, RS_FW, RS_HW, RS_SUM,
      RS_RST, RS_PREV, RS_CHEM, RS_FLREV
   } gcs_resp_e;

endpackage : gcs_pkg

/* File: rtl/gcs_decoder.sv */
`timescale 1ns/1ns

module gcs_decoder #(
   parameter logic [15:0] DEV_TYPE   = 16'h1234,  // Arbitrary identity value
   parameter logic [15:0] FW_REV     = 16'h0100,
   parameter logic [15:0] HW_REV     = 16'h0001,
   parameter logic [15:0] CHEM_CODE  = 16'h0100,
   parameter logic [15:0] FLASH_REV  = 16'h0001,
   parameter int          OSC_START_CYC = gcs_pkg::OSC_START_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Control command location, from the serial engine
   input  wire logic        cmd_wr,
   input  wire logic [15:0] cmd_data,
   output logic      [15:0] cmd_rd_data,
   // Link clock pin, asynchronous
   input  wire logic        link_clk,
   output logic             link_hold,
   // Power-mode events from the gauge core
   input  wire logic        sleep_entry,
   input  wire logic        in_sleep,
   input  wire logic        deep_idle_wake,
   output logic             osc_off_idle,
   output logic             deep_idle,
   // Gauge core status
   input  wire logic        full_access_locked,
   input  wire logic        coulomb_cal_active,
   input  wire logic        board_cal_active,
   input  wire logic        constant_power_gauging,
   input  wire logic        resistance_update_off,
   input  wire logic        voltage_unfit,
   input  wire logic        shutdown_cond,
   input  wire logic [15:0] reset_data,
   // Flash checksum engine
   output logic             flash_sum_start,
   input  wire logic        flash_sum_done,
   input  wire logic [15:0] flash_sum_value,
   // Requests to the gauge core
   output logic             gauging_algo_start,
   output logic             cal_start,
   output logic             full_reset_req,
   output logic             host_irq_enable,
   // Shutdown-signal pin
   output logic             shutdown_pin_out,
   output logic             shutdown_pin_oe_n
);

   // ************************************************************
   // Parameter checks
   // ************************************************************
   if (OSC_START_CYC < 1 || OSC_START_CYC > 262144) begin : g_chk
      $error("OSC_START_CYC out of range");
   end

   localparam logic [17:0] START_LAST = 18'(OSC_START_CYC - 1);

   // ************************************************************
   // State
   // ************************************************************
   logic [15:0]       resp_ff;
   gcs_pkg::gcs_resp_e sel_ff;
   gcs_pkg::gcs_resp_e nxt_sel;
   logic [15:0]       prev_ff;
   logic [15:0]       recall_ff;
   logic [15:0]       sum_ff;
   logic              sum_busy_ff;
   logic              sum_ok_ff;
   logic              locked_ff;
   logic              irq_en_ff;
   logic              pwroff_ff;
   logic              deep_req_ff;
   logic              deep_ff;
   logic              osc_arm_ff;
   logic              osc_idle_ff;
   logic              qen_ff;
   logic              vfit_ff;
   logic              hold_ff;
   logic [17:0]       hold_cnt_ff;
   logic              lk_s1_ff;
   logic              lk_s2_ff;
   logic              lk_s3_ff;
   logic              start_ff;
   logic              algo_ff;
   logic              cal_ff;
   logic              rst_req_ff;

   // ************************************************************
   // Subcommand decode
   // ************************************************************
   logic        is_sum;
   logic        is_rst;
   logic        is_prev;
   logic        is_osc;
   logic        is_lock;
   logic        is_algo;
   logic        is_cal;
   logic        is_reset;
   logic        protect;
   logic        take;
   logic        do_osc;
   logic        do_dset;
   logic        do_dclr;
   logic        do_pon;
   logic        do_poff;
   logic        do_ion;
   logic        do_ioff;
   logic        do_lock;
   logic        do_algo;
   logic        do_cal;
   logic        do_reset;
   logic        do_sum;
   logic        link_evt;
   logic        wake;
   logic        pin_act;
   logic [15:0] status_w;
   logic [15:0] resp_mux;

   // Codes barred while locked
   assign is_sum   = (cmd_data == gcs_pkg::SC_FL_SUM);
   assign is_rst   = (cmd_data == gcs_pkg::SC_RST_DATA);
   assign is_prev  = (cmd_data == gcs_pkg::SC_PREV);
   assign is_osc   = (cmd_data == gcs_pkg::SC_OSC_IDLE);
   assign is_lock  = (cmd_data == gcs_pkg::SC_LOCK);
   assign is_algo  = (cmd_data == gcs_pkg::SC_ALGO);
   assign is_cal   = (cmd_data == gcs_pkg::SC_CAL);
   assign is_reset = (cmd_data == gcs_pkg::SC_RESET);
   assign protect  = is_sum | is_rst | is_prev | is_osc | is_lock
                   | is_algo | is_cal | is_reset;
   assign take     = cmd_wr & ~(locked_ff & protect);

   // Command strobes
   assign do_osc   = take & is_osc;
   assign do_dset  = take & (cmd_data == gcs_pkg::SC_DEEP_SET);
   assign do_dclr  = take & (cmd_data == gcs_pkg::SC_DEEP_CLR);
   assign do_pon   = take & (cmd_data == gcs_pkg::SC_PWROFF_ON);
   assign do_poff  = take & (cmd_data == gcs_pkg::SC_PWROFF_NO);
   assign do_ion   = take & (cmd_data == gcs_pkg::SC_IRQ_ON);
   assign do_ioff  = take & (cmd_data == gcs_pkg::SC_IRQ_OFF);
   assign do_lock  = take & is_lock;
   assign do_algo  = take & is_algo;
   assign do_cal   = take & is_cal;
   assign do_reset = take & is_reset;
   // Locked: no new checksum, stored value still returned
   assign do_sum   = cmd_wr & is_sum & ~locked_ff;

   // ************************************************************
   // Response source select
   // ************************************************************
   // Unknown and reserved codes keep the current source
   always_comb begin
      nxt_sel = sel_ff;
      if (take) begin
         case (cmd_data)
            gcs_pkg::SC_STATUS:   nxt_sel = gcs_pkg::RS_STATUS;
            gcs_pkg::SC_DEV_TYPE: nxt_sel = gcs_pkg::RS_DEV;
            gcs_pkg::SC_FW_REV:   nxt_sel = gcs_pkg::RS_FW;
            gcs_pkg::SC_HW_REV:   nxt_sel = gcs_pkg::RS_HW;
            gcs_pkg::SC_FL_SUM:   nxt_sel = gcs_pkg::RS_SUM;
            gcs_pkg::SC_RST_DATA: nxt_sel = gcs_pkg::RS_RST;
            gcs_pkg::SC_PREV:     nxt_sel = gcs_pkg::RS_PREV;
            gcs_pkg::SC_CHEM:     nxt_sel = gcs_pkg::RS_CHEM;
            gcs_pkg::SC_FL_REV:   nxt_sel = gcs_pkg::RS_FLREV;
            default:              nxt_sel = sel_ff;
         endcase
      end
      // Locked checksum request still shows the stored sum
      if (cmd_wr & is_sum) begin
         nxt_sel = gcs_pkg::RS_SUM;
      end
   end

   // ************************************************************
   // Control-status word
   // ************************************************************
   assign pin_act = pwroff_ff & shutdown_cond;
   always_comb begin
      status_w                       = 16'h0000;  // Unused bit 9 reads 0
      status_w[gcs_pkg::B_PIN_ACT]   = pin_act;
      status_w[gcs_pkg::B_FA_LOCK]   = full_access_locked;
      status_w[gcs_pkg::B_LOCKED]    = locked_ff;
      status_w[gcs_pkg::B_SUM_OK]    = sum_ok_ff;
      status_w[gcs_pkg::B_CC_CAL]    = coulomb_cal_active;
      status_w[gcs_pkg::B_BRD_CAL]   = board_cal_active;
      status_w[gcs_pkg::B_IRQ_EN]    = irq_en_ff;
      status_w[gcs_pkg::B_PWROFF]    = pwroff_ff;
      status_w[gcs_pkg::B_DEEP_REQ]  = deep_req_ff;
      status_w[gcs_pkg::B_OSC_IDLE]  = osc_arm_ff;
      status_w[gcs_pkg::B_SLEEP]     = in_sleep | osc_idle_ff;
      status_w[gcs_pkg::B_CPWR]      = constant_power_gauging;
      status_w[gcs_pkg::B_RUP_OFF]   = resistance_update_off;
      status_w[gcs_pkg::B_VFIT]      = vfit_ff;
      status_w[gcs_pkg::B_QEN]       = qen_ff;
   end

   // Read value for the selected source
   always_comb begin
      case (sel_ff)
         gcs_pkg::RS_STATUS: resp_mux = status_w;
         gcs_pkg::RS_DEV:    resp_mux = DEV_TYPE;
         gcs_pkg::RS_FW:     resp_mux = FW_REV;
         gcs_pkg::RS_HW:     resp_mux = HW_REV;
         gcs_pkg::RS_SUM:    resp_mux = sum_ff;
         gcs_pkg::RS_RST:    resp_mux = reset_data;
         gcs_pkg::RS_PREV:   resp_mux = recall_ff;
         gcs_pkg::RS_CHEM:   resp_mux = CHEM_CODE;
         gcs_pkg::RS_FLREV:  resp_mux = FLASH_REV;
         default:            resp_mux = status_w;
      endcase
   end

   // Response register and source
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sel_ff  <= gcs_pkg::RS_STATUS;
         resp_ff <= gcs_pkg::RESP_RST;
      end else begin
         sel_ff  <= nxt_sel;
         resp_ff <= resp_mux;
      end
   end

   // Previous code: recall snapshots the last code below PREV_LIMIT before this request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_ff   <= gcs_pkg::PREV_RST;
         recall_ff <= gcs_pkg::PREV_RST;
      end else begin
         if (take && is_prev) begin
            recall_ff <= prev_ff;
         end
         if (cmd_wr && cmd_data < gcs_pkg::PREV_LIMIT) begin
            prev_ff <= cmd_data;
         end
      end
   end

   // ************************************************************
   // Checksum capture
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sum_ff      <= gcs_pkg::SUM_RST;
         sum_busy_ff <= 1'b0;
         sum_ok_ff   <= 1'b0;
      end else begin
         if (do_sum) begin
            sum_busy_ff <= 1'b1;
         end else if (flash_sum_done) begin
            sum_busy_ff <= 1'b0;
         end
         if (flash_sum_done && sum_busy_ff) begin
            sum_ff    <= flash_sum_value;
            sum_ok_ff <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Access state and host interrupt enable
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         locked_ff <= 1'b0;
         irq_en_ff <= 1'b0;
         pwroff_ff <= 1'b0;
      end else begin
         if (do_lock) begin
            locked_ff <= 1'b1;
         end
         if (do_ion) begin
            irq_en_ff <= 1'b1;
         end else if (do_ioff) begin
            irq_en_ff <= 1'b0;
         end
         if (do_pon) begin
            pwroff_ff <= 1'b1;
         end else if (do_poff) begin
            pwroff_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Gauging flags
   // ************************************************************
   // Max-capacity enable never clears; a new start beats an unfit report
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         qen_ff  <= 1'b0;
         vfit_ff <= 1'b0;
      end else begin
         if (do_algo) begin
            qen_ff <= 1'b1;
         end
         if (do_algo) begin
            vfit_ff <= 1'b1;
         end else if (voltage_unfit) begin
            vfit_ff <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Link activity detection
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lk_s1_ff <= 1'b1;  // Idle level of the link clock
         lk_s2_ff <= 1'b1;
         lk_s3_ff <= 1'b1;
      end else begin
         lk_s1_ff <= link_clk;
         lk_s2_ff <= lk_s1_ff;
         lk_s3_ff <= lk_s2_ff;
      end
   end

   assign link_evt = lk_s2_ff ^ lk_s3_ff;
   assign wake     = osc_idle_ff & link_evt;

   // ************************************************************
   // Oscillator-off idle
   // ************************************************************
   // Link activity in oscillator-off idle drops back to sleep and clears the mode bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         osc_arm_ff  <= 1'b0;
         osc_idle_ff <= 1'b0;
      end else begin
         if (do_osc) begin
            osc_arm_ff <= 1'b1;
         end else if (wake) begin
            osc_arm_ff <= 1'b0;
         end
         if (wake) begin
            osc_idle_ff <= 1'b0;
         end else if (osc_arm_ff && sleep_entry) begin
            osc_idle_ff <= 1'b1;
         end
      end
   end

   // Stretch link while the oscillator restarts; that message is lost
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hold_ff     <= 1'b0;
         hold_cnt_ff <= 18'h00000;
      end else if (wake) begin
         hold_ff     <= 1'b1;
         hold_cnt_ff <= START_LAST;
      end else if (hold_ff) begin
         if (hold_cnt_ff == 18'h00000) begin
            hold_ff <= 1'b0;
         end else begin
            hold_cnt_ff <= hold_cnt_ff - 18'h00001;
         end
      end
   end

   // ************************************************************
   // Deep idle
   // ************************************************************
   // A new request wins over the automatic clear on exit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         deep_req_ff <= 1'b0;
         deep_ff     <= 1'b0;
      end else begin
         if (do_dset) begin
            deep_req_ff <= 1'b1;
         end else if (do_dclr || (deep_ff && deep_idle_wake)) begin
            deep_req_ff <= 1'b0;
         end
         if (do_dclr || deep_idle_wake) begin
            deep_ff <= 1'b0;
         end else if (deep_req_ff && sleep_entry) begin
            deep_ff <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Request pulses
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         start_ff   <= 1'b0;
         algo_ff    <= 1'b0;
         cal_ff     <= 1'b0;
         rst_req_ff <= 1'b0;
      end else begin
         start_ff   <= do_sum;
         algo_ff    <= do_algo;
         cal_ff     <= do_cal;
         rst_req_ff <= do_reset;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign cmd_rd_data        = resp_ff;
   assign link_hold          = hold_ff;
   assign osc_off_idle       = osc_idle_ff;
   assign deep_idle          = deep_ff;
   assign flash_sum_start    = start_ff;
   assign gauging_algo_start = algo_ff;
   assign cal_start          = cal_ff;
   assign full_reset_req     = rst_req_ff;
   assign host_irq_enable    = irq_en_ff;
   // Pin released unless permitted and shutdown_cond is set; low requests external shutdown
   assign shutdown_pin_out   = 1'b0;
   assign shutdown_pin_oe_n  = ~pin_act;

endmodule : gcs_decoder

/* File: testbench/gcs_decoder_sva.sv */
`timescale 1ns/1ns
// ****************
// Decoder checks
// ****************
module gcs_decoder_sva #(
   parameter logic [15:0] DEV_TYPE = 16'h1234  // Arbitrary identity value
) (
   // Clock, reset, command port
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        cmd_wr,
   input wire logic [15:0] cmd_data,
   input wire logic [15:0] cmd_rd_data,
   // Pulses, levels, pin
   input wire logic        flash_sum_start,
   input wire logic        gauging_algo_start,
   input wire logic        cal_start,
   input wire logic        full_reset_req,
   input wire logic        host_irq_enable,
   input wire logic        shutdown_cond,
   input wire logic        shutdown_pin_out,
   input wire logic        shutdown_pin_oe_n
);
   logic lock_ff;
   logic pmt_ff;
   wire logic nxt_lock = lock_ff | (cmd_wr && cmd_data == gcs_pkg::SC_LOCK);
   wire logic nxt_pmt = (cmd_wr && cmd_data == gcs_pkg::SC_PWROFF_ON) |
                        (pmt_ff && !(cmd_wr && cmd_data == gcs_pkg::SC_PWROFF_NO));
   wire logic prot = cmd_wr && cmd_data inside {gcs_pkg::SC_ALGO, gcs_pkg::SC_CAL,
                                                gcs_pkg::SC_RESET, gcs_pkg::SC_FL_SUM};
   wire logic any_p = flash_sum_start | gauging_algo_start | cal_start | full_reset_req;
   // Shadow lock state and power-off permit
   always_ff @(posedge clk) begin
      lock_ff <= sys_rst ? 1'b0 : nxt_lock;
      pmt_ff  <= sys_rst ? 1'b0 : nxt_pmt;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Selecting write followed by a quiet cycle
   sequence s_sel(logic [15:0] c);
      cmd_wr && cmd_data == c ##1 !cmd_wr;
   endsequence
   property p_irq_on;
      cmd_wr && cmd_data == gcs_pkg::SC_IRQ_ON |=> host_irq_enable;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq enable not set");
   property p_irq_off;
      cmd_wr && cmd_data == gcs_pkg::SC_IRQ_OFF |=> !host_irq_enable;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq enable not cleared");
   property p_sum_go;
      !lock_ff && cmd_wr && cmd_data == gcs_pkg::SC_FL_SUM |=> flash_sum_start;
   endproperty
   a_sum_go: assert property (p_sum_go) else $error("checksum not started");
   property p_locked;
      lock_ff && prot |=> !any_p;
   endproperty
   a_locked: assert property (p_locked) else $error("locked code acted");
   property p_algo;
      !lock_ff && cmd_wr && cmd_data == gcs_pkg::SC_ALGO |=> gauging_algo_start;
   endproperty
   a_algo: assert property (p_algo) else $error("algorithm start missing");
   property p_cal;
      cal_start |-> $past(cmd_wr && cmd_data == gcs_pkg::SC_CAL && !lock_ff);
   endproperty
   a_cal: assert property (p_cal) else $error("stray calibration pulse");
   property p_rst;
      full_reset_req |-> $past(cmd_wr && cmd_data == gcs_pkg::SC_RESET && !lock_ff);
   endproperty
   a_rst: assert property (p_rst) else $error("stray reset pulse");
   property p_pin;
      shutdown_pin_oe_n == !(pmt_ff && shutdown_cond) && !shutdown_pin_out;
   endproperty
   a_pin: assert property (p_pin) else $error("shutdown pin wrong");
   property p_dev;
      s_sel(gcs_pkg::SC_DEV_TYPE) |=> cmd_rd_data == DEV_TYPE;
   endproperty
   a_dev: assert property (p_dev) else $error("device type wrong");
   property p_stat;
      s_sel(gcs_pkg::SC_STATUS) |=> cmd_rd_data[8] == $past(host_irq_enable) &&
         cmd_rd_data[13] == $past(lock_ff) && !cmd_rd_data[9] &&
         cmd_rd_data[15] == $past(!shutdown_pin_oe_n);
   endproperty
   a_stat: assert property (p_stat) else $error("status word wrong");
endmodule : gcs_decoder_sva

bind gcs_decoder gcs_decoder_sva #(.DEV_TYPE(DEV_TYPE)) u_gcs_decoder_sva (
   .clk, .sys_rst, .cmd_wr, .cmd_data, .cmd_rd_data, .flash_sum_start,
   .gauging_algo_start, .cal_start, .full_reset_req, .host_irq_enable,
   .shutdown_cond, .shutdown_pin_out, .shutdown_pin_oe_n
);

/* File: testbench/gcs_host_link.sv */
`timescale 1ns/1ns
// ****************
// Host link clock
// ****************
module gcs_host_link (
   // Frame request, stretch
   input wire logic frame_go,
   input wire logic link_hold,
   // Link clock pin
   output logic     link_clk
);
   initial link_clk = 1'b1;
   // Clock idles high; waits out a stretch
   always @(posedge frame_go) begin
      repeat (8) begin
         #160;
         wait (!link_hold);
         link_clk = ~link_clk;
      end
   end
endmodule : gcs_host_link

/* File: testbench/tb_gcs_decoder.sv */
`timescale 1ns/1ns
// ****************
// Decoder bench
// ****************
module tb_gcs_decoder;
   localparam int OSC = 8;
   localparam logic [15:0] IDV [5] = '{16'h2a51, 16'h0203, 16'h0004, 16'h0305, 16'h0006};
   localparam logic [15:0] IDC [5] = '{gcs_pkg::SC_DEV_TYPE, gcs_pkg::SC_FW_REV,
      gcs_pkg::SC_HW_REV, gcs_pkg::SC_CHEM, gcs_pkg::SC_FL_REV};
   localparam logic [15:0] LKC [4] = '{gcs_pkg::SC_ALGO, gcs_pkg::SC_CAL,
      gcs_pkg::SC_RESET, gcs_pkg::SC_FL_SUM};
   logic clk, sys_rst, cmd_wr, link_clk, link_hold, sleep_entry, in_sleep, deep_idle_wake;
   logic osc_off_idle, deep_idle, full_access_locked, coulomb_cal_active, board_cal_active;
   logic constant_power_gauging, resistance_update_off, voltage_unfit, shutdown_cond;
   logic flash_sum_start, flash_sum_done, gauging_algo_start, cal_start, full_reset_req;
   logic host_irq_enable, shutdown_pin_out, shutdown_pin_oe_n, frame_go;
   logic [15:0] cmd_data, cmd_rd_data, reset_data, flash_sum_value, st;
   int errors = 0, num_checks = 0, cycles = 0, n;
   gcs_decoder #(.DEV_TYPE(IDV[0]), .FW_REV(IDV[1]), .HW_REV(IDV[2]), .CHEM_CODE(IDV[3]),
      .FLASH_REV(IDV[4]), .OSC_START_CYC(OSC)) u_gcs_decoder (.clk, .sys_rst, .cmd_wr,
      .cmd_data, .cmd_rd_data, .link_clk, .link_hold, .sleep_entry, .in_sleep,
      .deep_idle_wake, .osc_off_idle, .deep_idle, .full_access_locked, .coulomb_cal_active,
      .board_cal_active, .constant_power_gauging, .resistance_update_off, .voltage_unfit,
      .shutdown_cond, .reset_data, .flash_sum_start, .flash_sum_done, .flash_sum_value,
      .gauging_algo_start, .cal_start, .full_reset_req, .host_irq_enable,
      .shutdown_pin_out, .shutdown_pin_oe_n);
   gcs_host_link u_gcs_host_link (.frame_go, .link_hold, .link_clk);
   // Clock and hang limit
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One whole subcommand word per write
   task automatic cmd(input logic [15:0] c);
      @(posedge clk) #1;
      cmd_wr = 1'b1;
      cmd_data = c;
      @(posedge clk) #1;
      cmd_wr = 1'b0;
   endtask : cmd
   task automatic rd(input logic [15:0] c, input logic [15:0] e);
      cmd(c);
      @(posedge clk) #1;
      chk(cmd_rd_data, e);
   endtask : rd
   task automatic pulse(ref logic s);
      @(posedge clk) #1;
      s = 1'b1;
      @(posedge clk) #1;
      s = 1'b0;
   endtask : pulse
   // Main sequence
   initial begin
      {cmd_wr, cmd_data, sleep_entry, deep_idle_wake, voltage_unfit, shutdown_cond} = '0;
      {flash_sum_done, flash_sum_value, frame_go, board_cal_active} = '0;
      {full_access_locked, coulomb_cal_active, in_sleep, constant_power_gauging} = '1;
      resistance_update_off = 1'b0;
      reset_data = 16'h5a3c;
      st = 16'h4818;
      sys_rst = 1'b1;
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      chk(cmd_rd_data, gcs_pkg::RESP_RST);
      rd(gcs_pkg::SC_STATUS, st);
      for (int i = 0; i < 5; i++) begin
         rd(IDC[i], IDV[i]);
      end
      rd(gcs_pkg::SC_RST_DATA, 16'h5a3c);
      cmd(gcs_pkg::SC_FL_SUM);
      chk(16'(flash_sum_start), 16'h0001);
      flash_sum_value = 16'hbeef;
      pulse(flash_sum_done);
      @(posedge clk) #1;
      chk(cmd_rd_data, 16'hbeef);
      cmd(16'h0006);
      @(posedge clk) #1;
      chk(cmd_rd_data, 16'hbeef);
      rd(gcs_pkg::SC_PREV, 16'h0006);
      cmd(16'h0030);
      rd(gcs_pkg::SC_PREV, gcs_pkg::SC_PREV);
      cmd(gcs_pkg::SC_IRQ_ON);
      st = st | 16'h1100;
      rd(gcs_pkg::SC_STATUS, st);
      shutdown_cond = 1'b1;
      cmd(gcs_pkg::SC_PWROFF_ON);
      chk(16'(shutdown_pin_oe_n), 16'h0000);
      rd(gcs_pkg::SC_STATUS, st | 16'h8080);
      cmd(gcs_pkg::SC_PWROFF_NO);
      chk(16'(shutdown_pin_oe_n), 16'h0001);
      cmd(gcs_pkg::SC_DEEP_SET);
      pulse(sleep_entry);
      chk(16'(deep_idle), 16'h0001);
      rd(gcs_pkg::SC_STATUS, st | 16'h0040);
      pulse(deep_idle_wake);
      rd(gcs_pkg::SC_STATUS, st);
      cmd(gcs_pkg::SC_DEEP_SET);
      pulse(sleep_entry);
      cmd(gcs_pkg::SC_DEEP_CLR);
      chk(16'(deep_idle), 16'h0000);
      cmd(gcs_pkg::SC_OSC_IDLE);
      pulse(sleep_entry);
      chk(16'(osc_off_idle), 16'h0001);
      rd(gcs_pkg::SC_STATUS, st | 16'h0020);
      frame_go = 1'b1;
      n = 0;
      while (link_hold !== 1'b1 && n < 100) begin
         @(posedge clk) #1;
         n++;
      end
      chk(16'(osc_off_idle), 16'h0000);
      n = 0;
      while (link_hold === 1'b1 && n < 100) begin
         @(posedge clk) #1;
         n++;
      end
      chk(16'(n), 16'(OSC));
      cmd(gcs_pkg::SC_ALGO);
      chk(16'(gauging_algo_start), 16'h0001);
      st = st | 16'h0003;
      rd(gcs_pkg::SC_STATUS, st);
      pulse(voltage_unfit);
      st = st & 16'hfffd;
      rd(gcs_pkg::SC_STATUS, st);
      cmd(gcs_pkg::SC_CAL);
      chk(16'(cal_start), 16'h0001);
      cmd(gcs_pkg::SC_RESET);
      chk(16'(full_reset_req), 16'h0001);
      cmd(gcs_pkg::SC_LOCK);
      st = st | 16'h2000;
      rd(gcs_pkg::SC_STATUS, st);
      for (int i = 0; i < 4; i++) begin
         cmd(LKC[i]);
         chk(16'({flash_sum_start, gauging_algo_start, cal_start, full_reset_req}), 16'h0);
      end
      rd(gcs_pkg::SC_FL_SUM, 16'hbeef);
      rd(gcs_pkg::SC_PREV, 16'hbeef);
      cmd(gcs_pkg::SC_IRQ_OFF);
      {full_access_locked, board_cal_active, resistance_update_off} = 3'b011;
      st = (st & 16'hfeff) ^ 16'h4404;
      rd(gcs_pkg::SC_STATUS, st);
      report_and_stop();
   end
endmodule : tb_gcs_decoder
